/* File: shared/clock_ctrl_consts.svh */
`ifndef CLOCK_CTRL_CONSTS_SVH
`define CLOCK_CTRL_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_CTRL_STATUS 8'h2e
`define ADDR_IRQ_STATUS  8'h31
`define ADDR_IRQ_CLEAR   8'h32
`define ADDR_IRQ_ENABLE  8'h33

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RESET       8'h00
`define IRQ_RESET        2'h0

// ----------------------------------------------------------------
// interrupt status bit positions
// ----------------------------------------------------------------
`define IRQ_BIT_PERIOD   0
`define IRQ_BIT_WAKE     1

// ----------------------------------------------------------------
// divide ratios
// ----------------------------------------------------------------
`define TB_DIV_0         18'h03e80
`define TB_DIV_1         18'h07d00
`define TB_DIV_2         18'h13880
`define TB_DIV_3         18'h30d40
`define CPU_DIV_0        5'h02
`define CPU_DIV_1        5'h04
`define CPU_DIV_2        5'h08
`define CPU_DIV_3        5'h10

`endif

/* File: shared/clock_ctrl_pkg.sv */
package clock_ctrl_pkg;

  // bit 7 down to bit 0 of the control/status register
  typedef struct packed {
    logic       clock_out_enable;
    logic [1:0] slow_divider_sel;
    logic       slow_mode_select;
    logic [1:0] timebase_sel;
    logic       osc_irq_enable;
    logic       timebase_flag;
  } ctrl_fields_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_ACTIVE_HALT,
    MODE_HALT,
    MODE_AUTO_WAKE_HALT
  } power_mode_t;

endpackage

/* File: design/period_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module period_divider #(
  parameter int W = 18
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         run_in,
  input  wire logic [W-1:0] limit_in,
  output logic              wrap_out,
  output logic [W-1:0]      count_out
);

  localparam logic [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] ZERO = {W{1'b0}};

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  wire          at_last;

  assign at_last    = (count_reg >= (limit_in - ONE));
  assign wrap_out   = run_in & at_last;
  assign count_next = !run_in ? count_reg :
                      at_last ? ZERO : count_reg + ONE;
  assign count_out  = count_reg;

  // frozen, not cleared, while run is low
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      count_reg <= ZERO;
    else
      count_reg <= count_next;
  end

endmodule // period_divider

`default_nettype wire

/* File: design/main_clock_ctrl_rtc.sv */
// Contract
// - prescaler, clock out, time base run concurrently
// - slow mode divides cpu clock 2/4/8/16
// - bit 7 puts oscillator clock on pin
// - time base divides by 16000/32000/80000/200000
// - new time base applies at period end
// - period end sets flag; read clears it
// - interrupt request when flag and enable set
// - enable set makes halt become active halt
// - wait keeps running; time base wakes it
// - active halt counts, registers frozen, wakes
// - halt freezes counter and registers
// - time base never wakes full halts
// - control register resets to zero
`timescale 1ns/1ps
`default_nettype none
`include "clock_ctrl_consts.svh"

module main_clock_ctrl_rtc
  import clock_ctrl_pkg::*;
#(
  parameter logic [17:0] TB_DIV_0 = `TB_DIV_0,
  parameter logic [17:0] TB_DIV_1 = `TB_DIV_1,
  parameter logic [17:0] TB_DIV_2 = `TB_DIV_2,
  parameter logic [17:0] TB_DIV_3 = `TB_DIV_3
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     sys_rst_in,
  input  wire clock_ctrl_pkg::reg_req_t bus_in,
  input  wire logic                     halt_req_in,
  input  wire logic                     auto_wake_halt_in,
  input  wire logic                     wait_req_in,
  input  wire logic                     wait_wake_in,
  input  wire logic                     halt_wake_in,
  output logic [7:0]                    rd_data_out,
  output logic                          cpu_clk_en_out,
  output logic                          clk_out_sel_out,
  output logic                          rtc_irq_req_out,
  output logic                          irq_out,
  output clock_ctrl_pkg::power_mode_t   power_mode_out
);

  import clock_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ctrl_fields_t ctrl_reg;
  ctrl_fields_t ctrl_next;
  power_mode_t  mode_reg;
  power_mode_t  mode_next;
  logic [1:0]   tb_active_reg;
  logic [1:0]   tb_active_next;
  logic [1:0]   irq_status_reg;
  logic [1:0]   irq_status_next;
  logic [1:0]   irq_enable_reg;
  logic [1:0]   irq_enable_next;
  logic [7:0]   rd_data_reg;
  logic [7:0]   rd_data_next;
  logic         cpu_en_reg;
  logic         cpu_en_next;
  logic         clk_out_reg;
  logic         rtc_req_reg;
  logic         irq_reg;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire        hit_ctrl    = (bus_in.addr == `ADDR_CTRL_STATUS);
  wire        hit_status  = (bus_in.addr == `ADDR_IRQ_STATUS);
  wire        hit_clear   = (bus_in.addr == `ADDR_IRQ_CLEAR);
  wire        hit_enable  = (bus_in.addr == `ADDR_IRQ_ENABLE);
  wire        full_halt   = (mode_reg == MODE_HALT) ||
                            (mode_reg == MODE_AUTO_WAKE_HALT);
  wire        any_halt    = full_halt || (mode_reg == MODE_ACTIVE_HALT);
  // bus writes and flag-clearing reads only land while the core is awake
  wire        regs_live   = !any_halt;
  wire        wr_ctrl     = bus_in.wr && hit_ctrl && regs_live;
  wire        rd_ctrl     = bus_in.rd && hit_ctrl && regs_live;
  wire        wr_clear    = bus_in.wr && hit_clear && regs_live;
  wire        wr_enable   = bus_in.wr && hit_enable && regs_live;
  wire        rtc_req     = ctrl_reg.timebase_flag &&
                            ctrl_reg.osc_irq_enable;
  wire        tb_run      = !full_halt;
  wire        cpu_div_run = ctrl_reg.slow_mode_select && !any_halt;
  wire        period_end;
  wire        cpu_wrap;
  wire [17:0] tb_count;
  wire [17:0] tb_limit;
  wire [4:0]  cpu_limit;

  // ----------------------------------------------------------------
  // dividers, independent of each other
  // ----------------------------------------------------------------
  // the running period keeps its own ratio until it ends
  assign tb_limit = (tb_active_reg == 2'h0) ? TB_DIV_0 :
                    (tb_active_reg == 2'h1) ? TB_DIV_1 :
                    (tb_active_reg == 2'h2) ? TB_DIV_2 :
                                              TB_DIV_3;

  assign cpu_limit =
    (ctrl_reg.slow_divider_sel == 2'h0) ? `CPU_DIV_0 :
    (ctrl_reg.slow_divider_sel == 2'h1) ? `CPU_DIV_1 :
    (ctrl_reg.slow_divider_sel == 2'h2) ? `CPU_DIV_2 :
                                          `CPU_DIV_3;

  period_divider #(
    .W (18)
  ) timebase_div (
    .clk_in    (core_clk_in),
    .rst_in    (sys_rst_in),
    .run_in    (tb_run),
    .limit_in  (tb_limit),
    .wrap_out  (period_end),
    .count_out (tb_count)
  );

  period_divider #(
    .W (5)
  ) cpu_div (
    .clk_in    (core_clk_in),
    .rst_in    (sys_rst_in),
    .run_in    (cpu_div_run),
    .limit_in  (cpu_limit),
    .wrap_out  (cpu_wrap),
    .count_out ()
  );

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  assign tb_active_next = period_end ? ctrl_reg.timebase_sel
                                     : tb_active_reg;

  // cpu clock stops in every halt mode
  assign cpu_en_next = any_halt ? 1'b0 :
                       ctrl_reg.slow_mode_select ? cpu_wrap
                                                 : 1'b1;

  // set beats the read that would clear it
  wire        flag_next = period_end ||
    (ctrl_reg.timebase_flag && !rd_ctrl);
  // software owns bits 7:1; bit 0 is set by hardware only
  assign ctrl_next = {wr_ctrl ? bus_in.wdata[7:1] : ctrl_reg[7:1],
                      flag_next};

  wire        wake_evt = any_halt && (mode_next == MODE_RUN);
  wire [1:0]  irq_set  = {wake_evt, period_end};
  wire [1:0]  irq_clr  = wr_clear ? bus_in.wdata[1:0] : 2'h0;
  assign irq_status_next = irq_set | (irq_status_reg & ~irq_clr);
  assign irq_enable_next = wr_enable ? bus_in.wdata[1:0]
                                     : irq_enable_reg;

  assign rd_data_next =
    !bus_in.rd ? 8'h00 :
    hit_ctrl   ? ctrl_reg :
    hit_status ? {6'h00, irq_status_reg} :
    hit_enable ? {6'h00, irq_enable_reg} :
                 8'h00;

  // ----------------------------------------------------------------
  // power mode
  // ----------------------------------------------------------------
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_RUN:
      begin
        if (halt_req_in)
        begin
          if (ctrl_reg.osc_irq_enable)
            mode_next = MODE_ACTIVE_HALT;
          else if (auto_wake_halt_in)
            mode_next = MODE_AUTO_WAKE_HALT;
          else
            mode_next = MODE_HALT;
        end
        else if (wait_req_in)
          mode_next = MODE_WAIT;
      end
      MODE_WAIT:
      begin
        if (rtc_req || wait_wake_in)
          mode_next = MODE_RUN;
      end
      MODE_ACTIVE_HALT:
      begin
        if (rtc_req || halt_wake_in)
          mode_next = MODE_RUN;
      end
      MODE_HALT,
      MODE_AUTO_WAKE_HALT:
      begin
        // the time base request is ignored here
        if (halt_wake_in)
          mode_next = MODE_RUN;
      end
      default:
        mode_next = MODE_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_reg       <= `CTRL_RESET;
      tb_active_reg  <= 2'h0;
      mode_reg       <= MODE_RUN;
      irq_status_reg <= `IRQ_RESET;
      irq_enable_reg <= `IRQ_RESET;
      rd_data_reg    <= 8'h00;
    end
    else
    begin
      ctrl_reg       <= ctrl_next;
      tb_active_reg  <= tb_active_next;
      mode_reg       <= mode_next;
      irq_status_reg <= irq_status_next;
      irq_enable_reg <= irq_enable_next;
      rd_data_reg    <= rd_data_next;
    end
  end

  // outputs follow the next values so they match the registers
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cpu_en_reg  <= 1'b0;
      clk_out_reg <= 1'b0;
      rtc_req_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end
    else
    begin
      cpu_en_reg  <= cpu_en_next;
      clk_out_reg <= ctrl_next.clock_out_enable;
      rtc_req_reg <= ctrl_next.timebase_flag &&
                     ctrl_next.osc_irq_enable;
      irq_reg     <= |(irq_status_next & irq_enable_next);
    end
  end

  assign rd_data_out     = rd_data_reg;
  assign cpu_clk_en_out  = cpu_en_reg;
  assign clk_out_sel_out = clk_out_reg;
  assign rtc_irq_req_out = rtc_req_reg;
  assign irq_out         = irq_reg;
  assign power_mode_out  = mode_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_flag_set_end:
    assert property (period_end |=> ctrl_reg.timebase_flag)
    else $error("flag not set at period end");

  a_flag_read_clear:
    assert property (rd_ctrl && !period_end |=> !ctrl_reg.timebase_flag)
    else $error("read did not clear flag");

  a_flag_race_set:
    assert property (rd_ctrl && period_end
                     |=> ctrl_reg.timebase_flag ##1
                         (ctrl_reg.timebase_flag || $past(rd_ctrl)))
    else $error("period end lost to read");

  a_rtc_req_tie:
    assert property (rtc_irq_req_out ==
                     (ctrl_reg.timebase_flag && ctrl_reg.osc_irq_enable))
    else $error("rtc request mismatch");

  a_halt_becomes_active:
    assert property (mode_reg == MODE_RUN && halt_req_in &&
                     ctrl_reg.osc_irq_enable
                     |=> power_mode_out == MODE_ACTIVE_HALT)
    else $error("halt did not enter active halt");

  a_full_halt_hold:
    assert property (full_halt && !halt_wake_in
                     |=> full_halt && $stable(tb_count) &&
                         $stable(ctrl_reg))
    else $error("full halt not frozen");

  a_active_counts:
    assert property (mode_reg == MODE_ACTIVE_HALT && !period_end
                     |=> tb_count == $past(tb_count) + 18'h00001 &&
                         ctrl_reg[7:1] == $past(ctrl_reg[7:1]))
    else $error("active halt counter or registers wrong");

  a_wait_wakes:
    assert property (mode_reg == MODE_WAIT && rtc_req
                     |=> power_mode_out == MODE_RUN)
    else $error("time base did not end wait");

  a_tb_deferred:
    assert property (!period_end |=> $stable(tb_active_reg))
    else $error("time base changed mid period");

  a_normal_cpu:
    assert property (!ctrl_reg.slow_mode_select && !any_halt
                     |=> cpu_clk_en_out)
    else $error("cpu clock gated in normal mode");

  a_slow_div16:
    assert property (cpu_div_run && $past(cpu_div_run) &&
                     ctrl_reg.slow_divider_sel == 2'h3 &&
                     cpu_clk_en_out && !wr_ctrl
                     |=> !cpu_clk_en_out)
    else $error("slow divider enable too long");

  a_clk_out_sel:
    assert property (clk_out_sel_out == ctrl_reg.clock_out_enable)
    else $error("clock out select mismatch");

  c_period_end:  cover property (period_end ##1 rtc_irq_req_out);
  c_active_wake: cover property (mode_reg == MODE_ACTIVE_HALT && rtc_req
                                 ##1 mode_reg == MODE_RUN);
  c_read_race:   cover property (rd_ctrl && period_end);
  c_slow_mode:   cover property (cpu_div_run && cpu_wrap);

endmodule // main_clock_ctrl_rtc

`default_nettype wire

/* File: test/cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cpu_model (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire clock_ctrl_pkg::power_mode_t mode_in,
  input  wire logic                        wake_en_in,
  input  wire logic [3:0]                  dly_in,
  output logic                             wake_out
);
  import clock_ctrl_pkg::*;

  logic [3:0] cnt_reg;

  // ----------------------------------------------------------------
  // wake source, held like a pending irq until back in run
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_reg  <= 4'h0;
      wake_out <= 1'b0;
    end
    else if (mode_in == MODE_RUN || !wake_en_in)
    begin
      cnt_reg  <= 4'h0;
      wake_out <= 1'b0;
    end
    else if (cnt_reg >= dly_in)
      wake_out <= 1'b1;
    else
      cnt_reg <= cnt_reg + 4'h1;
  end
endmodule // cpu_model

`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "clock_ctrl_consts.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module tb_top;
  import clock_ctrl_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  reg_req_t    bus = '0;
  logic        halt_req = 1'b0;
  logic        aw_halt = 1'b0;
  logic        wait_req = 1'b0;
  logic        wake_en = 1'b0;
  logic [3:0]  dly = 4'h3;
  logic        wake;
  logic [7:0]  rd_data;
  logic        cpu_en;
  logic        clk_sel;
  logic        rtc_req;
  logic        irq;
  power_mode_t mode;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          n;
  int          k;
  logic [7:0]  ctrl_exp;
  logic [7:0]  d;
  logic [7:0]  wv;
  logic [7:0]  r;
  logic [1:0]  cur;
  logic [1:0]  s;

  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  // short periods keep the run small
  main_clock_ctrl_rtc #(
    .TB_DIV_0 (18'h00010),
    .TB_DIV_1 (18'h00020),
    .TB_DIV_2 (18'h00050),
    .TB_DIV_3 (18'h000c8)
  ) dut (
    .core_clk_in       (clk),
    .sys_rst_in        (rst),
    .bus_in            (bus),
    .halt_req_in       (halt_req),
    .auto_wake_halt_in (aw_halt),
    .wait_req_in       (wait_req),
    .wait_wake_in      (wake),
    .halt_wake_in      (wake),
    .rd_data_out       (rd_data),
    .cpu_clk_en_out    (cpu_en),
    .clk_out_sel_out   (clk_sel),
    .rtc_irq_req_out   (rtc_req),
    .irq_out           (irq),
    .power_mode_out    (mode)
  );

  cpu_model partner (
    .clk_in     (clk),
    .rst_in     (rst),
    .mode_in    (mode),
    .wake_en_in (wake_en),
    .dly_in     (dly),
    .wake_out   (wake)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int div_of(input logic [1:0] sel);
    case (sel)
      2'h0: return 16;
      2'h1: return 32;
      2'h2: return 80;
      default: return 200;
    endcase
  endfunction

  // every access leaves one idle cycle so strobes never double-assign
  // whole bytes only: a read-modify-write would eat the flag
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    v = rd_data;
  endtask

  task automatic pulse(input logic to_halt);
    if (to_halt)
      halt_req <= 1'b1;
    else
      wait_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    wait_req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_run(input int lim);
    k = 0;
    while (mode !== MODE_RUN && k < lim)
    begin
      @(posedge clk);
      k++;
    end
    `CHK("wake", MODE_RUN, mode)
  endtask

  // entered one edge after rtc_req rose; returns cycles to next rise
  task automatic gap(output int c);
    rd(`ADDR_CTRL_STATUS, d);
    `CHK("flag_rd", {ctrl_exp[7:1], 1'b1}, d)
    wr(`ADDR_CTRL_STATUS, wv);
    ctrl_exp = wv;
    `CHK("clk_out", wv[7], clk_sel)
    c = 4;
    while (rtc_req !== 1'b1 && c < 400)
    begin
      @(posedge clk);
      c++;
    end
  endtask

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #80000;
    n_mismatch++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    k = $urandom(76);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`ADDR_CTRL_STATUS, d);
    `CHK("ctrl_rst", 8'h00, d)
    rd(8'h40, d);
    `CHK("unmapped", 8'h00, d)
    ctrl_exp = 8'h02;
    wr(`ADDR_CTRL_STATUS, 8'h02);
    n = 0;
    while (rtc_req !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    cur = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      s = 2'(i + 1);
      r = 8'($urandom());
      wv = {r[7:4], s, 2'b10};
      gap(n);
      `CHK("period_old", div_of(cur), n)
      gap(n);
      `CHK("period_new", div_of(s), n)
      cur = s;
    end
    for (int i = 0; i < 6; i++)
    begin
      r = 8'($urandom());
      wv = {1'b0, r[6:4], 4'hc};
      if (i < 4)
        wv[6:4] = {2'(i), 1'b1};
      wr(`ADDR_CTRL_STATUS, wv);
      repeat (4) @(posedge clk);
      n = 0;
      repeat (64)
      begin
        @(posedge clk);
        if (cpu_en === 1'b1)
          n++;
      end
      `CHK("cpu_en", wv[4] ? 64 / (2 << wv[6:5]) : 64, n)
    end
    // poll the flag so the clear below lands far from a period end
    n = 0;
    d = 8'h00;
    while (d[0] !== 1'b1 && n < 150)
    begin
      rd(`ADDR_CTRL_STATUS, d);
      n++;
    end
    wr(`ADDR_IRQ_ENABLE, 8'h01);
    n = 0;
    while (irq !== 1'b1 && n < 250)
    begin
      @(posedge clk);
      n++;
    end
    wr(`ADDR_IRQ_CLEAR, 8'h01);
    `CHK("irq_clr", 1'b0, irq)
    wr(`ADDR_IRQ_ENABLE, 8'h00);
    repeat (210) @(posedge clk);
    `CHK("irq_mask", 1'b0, irq)
    `CHK("rtc_off", 1'b0, rtc_req)
    rd(`ADDR_IRQ_STATUS, d);
    `CHK("sticky", 1'b1, d[0])
    wr(`ADDR_IRQ_CLEAR, 8'h01);
    wr(`ADDR_CTRL_STATUS, 8'h02);
    `CHK("rtc_on", 1'b1, rtc_req)
    // halt just after a period end so the wake is a full period away
    rd(`ADDR_CTRL_STATUS, d);
    n = 0;
    while (rtc_req !== 1'b1 && n < 250)
    begin
      @(posedge clk);
      n++;
    end
    rd(`ADDR_CTRL_STATUS, d);
    pulse(1'b1);
    `CHK("act_halt", MODE_ACTIVE_HALT, mode)
    wr(`ADDR_CTRL_STATUS, 8'h82);
    wait_run(40);
    `CHK("frozen", 1'b0, clk_sel)
    for (int i = 0; i < 2; i++)
    begin
      wr(`ADDR_CTRL_STATUS, 8'h00);
      aw_halt <= i[0];
      pulse(1'b1);
      repeat (40) @(posedge clk);
      `CHK("halt", i ? MODE_AUTO_WAKE_HALT : MODE_HALT, mode)
      `CHK("cpu_off", 1'b0, cpu_en)
      dly <= 4'($urandom());
      wake_en <= 1'b1;
      @(posedge clk);
      wait_run(40);
      wake_en <= 1'b0;
      repeat (2) @(posedge clk);
    end
    wr(`ADDR_CTRL_STATUS, 8'h02);
    rd(`ADDR_CTRL_STATUS, d);
    pulse(1'b0);
    `CHK("wait", MODE_WAIT, mode)
    wait_run(40);
    finish_test();
  end
endmodule // tb_top

`default_nettype wire
